// ---- shared/dcs_defs.svh ----
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define DCS_ADDR_W 24
`define DCS_CTRL_RESET 8'h00
`define DCS_ZERO32 32'h00000000

// ----------------------------------------------------------------------
// channel control register fields
// ----------------------------------------------------------------------
`define DCS_BIT_SIZE 7
`define DCS_BIT_STEP_DIR 6
`define DCS_BIT_REPEAT 5
`define DCS_BIT_XDIR 4
`define DCS_SRC_MSB 3
`define DCS_SRC_LSB 0

// ----------------------------------------------------------------------
// activation source codes
// ----------------------------------------------------------------------
`define DCS_SRC_NONE 4'h0
`define DCS_SRC_ADC 4'h1
`define DCS_SRC_EXT_EDGE 4'h2
`define DCS_SRC_EXT_LEVEL 4'h3
`define DCS_SRC_SCI0_TX 4'h4
`define DCS_SRC_SCI0_RX 4'h5
`define DCS_SRC_SCI1_TX 4'h6
`define DCS_SRC_SCI1_RX 4'h7
`define DCS_SRC_TPU0 4'h8
`define DCS_SRC_TPU5 4'hD

// ----------------------------------------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define DCS_REG_CTRL_A 4'h0
`define DCS_REG_CTRL_B 4'h1
`define DCS_REG_BAND 4'h2
`define DCS_REG_MAR_A 4'h3
`define DCS_REG_MAR_B 4'h4
`define DCS_REG_IO_ADDR_REG_A 4'h5
`define DCS_REG_IO_ADDR_REG_B 4'h6
`define DCS_REG_CNT_A 4'h7
`define DCS_REG_CNT_B 4'h8
`define DCS_REG_STATUS 4'h9
`define DCS_REG_MASK 4'hA
`define DCS_REG_STATE 4'hB

// ----------------------------------------------------------------------
// band control bits
// ----------------------------------------------------------------------
`define DCS_BAND_SINGLE 0
`define DCS_BAND_EN_A 1
`define DCS_BAND_EN_B 2
`define DCS_BAND_IRQEN_A 3
`define DCS_BAND_IRQEN_B 4

// ----------------------------------------------------------------------
// address and count arithmetic
// ----------------------------------------------------------------------
`define DCS_IO_TOP 8'hFF
`define DCS_STEP_BYTE 24'h000001
`define DCS_STEP_WORD 24'h000002
`define DCS_CNT_LAST 16'h0001
`define DCS_CNT_ONE 16'h0001
`define DCS_RPT_LAST 8'h01
`define DCS_RPT_ONE 8'h01

`endif

// ---- shared/dcs_pkg.sv ----
package dcs_pkg;
  `include "dcs_defs.svh"

  // controller sequencing, one-hot
  typedef enum logic [1:0] {
    DCS_ST_IDLE = 2'b01,
    DCS_ST_BUSY = 2'b10
  } dcs_fsm_t;

  // transfer mode picked by repeat select and end interrupt enable
  typedef enum logic [1:0] {
    DCS_MODE_SEQ = 2'h0,
    DCS_MODE_RPT = 2'h1,
    DCS_MODE_IDLE = 2'h2
  } dcs_mode_t;

  // on-chip request sources, levels
  typedef struct packed {
    logic adc_end;
    logic sci0_tx;
    logic sci0_rx;
    logic sci1_tx;
    logic sci1_rx;
    logic [5:0] tpu_a;
  } dcs_req_t;

  // one transfer order to the bus side
  typedef struct packed {
    logic valid;
    logic chan_b;
    logic word;
    logic single;
    logic ack_read;
    logic [`DCS_ADDR_W-1:0] src;
    logic [`DCS_ADDR_W-1:0] dst;
  } dcs_xfer_t;

  // source selector state
  typedef struct packed {
    logic prev_ext_n;
    logic edge_pend;
  } dcs_sel_state_t;

  // whole state of the top module
  typedef struct packed {
    dcs_fsm_t fsm;
    logic cur;
    logic [1:0][7:0] ctrl;
    logic [1:0][`DCS_ADDR_W-1:0] memory_addr_reg;
    logic [1:0][`DCS_ADDR_W-1:0] mar_start;
    logic [1:0][15:0] io_addr_reg;
    logic [1:0][15:0] cnt;
    logic single_sel;
    logic [1:0] en;
    logic [1:0] irqen;
    logic [1:0] sts;
    logic [1:0] msk;
    logic first_pend;
    dcs_xfer_t xfer;
    logic ack_n;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
  } dcs_state_t;
endpackage

// ---- rtl/dcs_src_sel.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// activation source selector for one channel
// ----------------------------------------------------------------------
module dcs_src_sel import dcs_pkg::*; #(
  parameter bit CHAN_B = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // selection
  input wire logic [3:0] code,
  input wire logic first_pend,
  input wire logic take,
  // sources
  input wire dcs_req_t req,
  input wire logic ext_req_n,
  // result
  output logic hit
);
  dcs_sel_state_t st; // registered state
  dcs_sel_state_t nx; // next state
  logic fall; // falling edge on the external pin

  // source decode and edge memory
  always_comb begin
    nx = st;
    fall = st.prev_ext_n && !ext_req_n;
    hit = 1'b0;
    nx.prev_ext_n = ext_req_n;
    // a fall seen while busy is kept until the channel takes it; a fresh fall in the
    // taking cycle survives, so a second request is not lost (set wins over clear)
    nx.edge_pend = take ? (st.edge_pend && fall) : (st.edge_pend || fall);
    // [R8] none or converter end
    if (code == `DCS_SRC_ADC) begin
      hit = req.adc_end;
    end
    // [R11] external pin only on channel b
    else if (code == `DCS_SRC_EXT_EDGE) begin
      // [R12] first transfer taken on low level
      hit = CHAN_B && (st.edge_pend || fall || (first_pend && !ext_req_n));
    end else if (code == `DCS_SRC_EXT_LEVEL) begin
      hit = CHAN_B && !ext_req_n;
    end
    // [R9] serial sources in order
    else if (code == `DCS_SRC_SCI0_TX) begin
      hit = req.sci0_tx;
    end else if (code == `DCS_SRC_SCI0_RX) begin
      hit = req.sci0_rx;
    end else if (code == `DCS_SRC_SCI1_TX) begin
      hit = req.sci1_tx;
    end else if (code == `DCS_SRC_SCI1_RX) begin
      hit = req.sci1_rx;
    end
    // [R10] timer capture sources, top codes unassigned
    else if (code >= `DCS_SRC_TPU0 && code <= `DCS_SRC_TPU5) begin
      hit = req.tpu_a[code[2:0]];
    end
    // stale edges must not fire after a source change
    if (code != `DCS_SRC_EXT_EDGE) begin
      nx.edge_pend = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= '{prev_ext_n: 1'b1, edge_pend: 1'b0};
    end else begin
      st <= nx;
    end
  end
endmodule // dcs_src_sel

// ---- rtl/dcs_top.sv ----
`timescale 1ns/1ps
// Contract
// [R1] control register 8 bits, cleared reset/standby
// [R2] size bit picks byte or word
// [R3] address steps 1 or 2, up/down
// [R4] idle mode holds memory address
// [R5] repeat and irq-enable select mode
// [R6] dual mode direction swaps source/destination
// [R7] single mode ack pin read/write strobe
// [R8] source code zero none, one converter
// [R9] codes four-seven serial sources
// [R10] codes eight-thirteen timers, rest unassigned
// [R11] external pin codes only channel b
// [R12] first edge transfer triggered by level
// [R13] shared source: higher priority channel first
// [R14] single address select affects channel b
// [R15] io address top byte all ones
// [R16] external device drives/captures data on strobes
// [R17] external requester holds request per transfer
module dcs_top import dcs_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic standby_n,
  // avalon-mm register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // request sources
  input wire dcs_req_t req_in,
  input wire logic ext_req_n,
  // transfer order to the bus side
  output dcs_xfer_t xfer_out,
  input wire logic xfer_done,
  // external acknowledge pin, low active
  output logic xfer_ack_n,
  // interrupt
  output logic irq
);
  dcs_state_t st; // registered state
  dcs_state_t nx; // next state
  logic [1:0] hit; // requested by selected source
  logic [1:0] take; // channel started this cycle
  logic [31:0] rd_word; // read mux
  logic [31:0] wv; // merged write value
  logic [3:0] widx; // register word index
  dcs_mode_t mode_cur; // mode of the channel in service
  localparam dcs_state_t DCS_ST_RST = '{fsm: DCS_ST_IDLE, wreq: 1'b1, ack_n: 1'b1, default: '0};

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // mode from repeat select and end irq enable
  function automatic dcs_mode_t mode_of(input logic rpt, input logic ie);
    // [R5] mode table
    if (!rpt) begin
      return DCS_MODE_SEQ;
    end
    return ie ? DCS_MODE_IDLE : DCS_MODE_RPT;
  endfunction

  // memory address after one transfer
  function automatic logic [`DCS_ADDR_W-1:0] step_addr(input logic [`DCS_ADDR_W-1:0] a, input logic word,
                                                       input logic down);
    logic [`DCS_ADDR_W-1:0] s;
    // [R3] step by size
    s = word ? `DCS_STEP_WORD : `DCS_STEP_BYTE;
    return down ? a - s : a + s;
  endfunction

  // build the transfer order of one channel
  function automatic dcs_xfer_t build(input logic c, input logic [7:0] cr, input logic [`DCS_ADDR_W-1:0] m,
                                      input logic [15:0] io, input logic sgl);
    dcs_xfer_t x;
    logic [`DCS_ADDR_W-1:0] ioa;
    x = '0;
    // [R15] io window sits at the top of the map
    ioa = {`DCS_IO_TOP, io};
    x.valid = 1'b1;
    x.chan_b = c;
    // [R2] transfer unit
    x.word = cr[`DCS_BIT_SIZE];
    // [R14] only channel b may run single address
    x.single = sgl && c;
    if (x.single) begin
      // [R7] direction picks strobe sense
      x.ack_read = cr[`DCS_BIT_XDIR];
      x.src = cr[`DCS_BIT_XDIR] ? '0 : m;
      x.dst = cr[`DCS_BIT_XDIR] ? m : '0;
    end else begin
      // [R6] direction swaps roles
      x.src = cr[`DCS_BIT_XDIR] ? ioa : m;
      x.dst = cr[`DCS_BIT_XDIR] ? m : ioa;
    end
    return x;
  endfunction

  // --------------------------------------------------------------------
  // source selectors
  // --------------------------------------------------------------------
  dcs_src_sel #(.CHAN_B(1'b0)) u_sel_a (
    .clock(clock),
    .resetn(resetn),
    .code(st.ctrl[0][`DCS_SRC_MSB:`DCS_SRC_LSB]),
    .first_pend(1'b0),
    .take(take[0]),
    .req(req_in),
    .ext_req_n(ext_req_n),
    .hit(hit[0])
  );

  dcs_src_sel #(.CHAN_B(1'b1)) u_sel_b (
    .clock(clock),
    .resetn(resetn),
    .code(st.ctrl[1][`DCS_SRC_MSB:`DCS_SRC_LSB]),
    .first_pend(st.first_pend),
    .take(take[1]),
    .req(req_in),
    .ext_req_n(ext_req_n),
    .hit(hit[1])
  );

  // --------------------------------------------------------------------
  // register read mux
  // --------------------------------------------------------------------
  // unmapped words read as zero
  always_comb begin
    rd_word = `DCS_ZERO32;
    unique case (avs_address[5:2])
      `DCS_REG_CTRL_A: rd_word[7:0] = st.ctrl[0];
      `DCS_REG_CTRL_B: rd_word[7:0] = st.ctrl[1];
      `DCS_REG_BAND: begin
        rd_word[`DCS_BAND_SINGLE] = st.single_sel;
        rd_word[`DCS_BAND_EN_A] = st.en[0];
        rd_word[`DCS_BAND_EN_B] = st.en[1];
        rd_word[`DCS_BAND_IRQEN_A] = st.irqen[0];
        rd_word[`DCS_BAND_IRQEN_B] = st.irqen[1];
      end
      `DCS_REG_MAR_A: rd_word[`DCS_ADDR_W-1:0] = st.memory_addr_reg[0];
      `DCS_REG_MAR_B: rd_word[`DCS_ADDR_W-1:0] = st.memory_addr_reg[1];
      `DCS_REG_IO_ADDR_REG_A: rd_word[15:0] = st.io_addr_reg[0];
      `DCS_REG_IO_ADDR_REG_B: rd_word[15:0] = st.io_addr_reg[1];
      `DCS_REG_CNT_A: rd_word[15:0] = st.cnt[0];
      `DCS_REG_CNT_B: rd_word[15:0] = st.cnt[1];
      `DCS_REG_STATUS: rd_word[1:0] = st.sts;
      `DCS_REG_MASK: rd_word[1:0] = st.msk;
      `DCS_REG_STATE: rd_word[3:0] = {st.first_pend, st.cur, st.fsm};
      default: rd_word = `DCS_ZERO32;
    endcase
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    nx = st;
    take = 2'b00;
    widx = avs_address[5:2];
    wv = `DCS_ZERO32;
    mode_cur = mode_of(st.ctrl[st.cur][`DCS_BIT_REPEAT], st.irqen[st.cur]);
    // bus: one wait cycle, then answer for exactly one cycle
    nx.wreq = 1'b1;
    if ((avs_read || avs_write) && st.wreq) begin
      nx.wreq = 1'b0;
      nx.rdata = avs_read ? rd_word : `DCS_ZERO32;
    end
    // writes land at the edge where waitrequest is seen low
    if (avs_write && !st.wreq) begin
      unique case (widx)
        // [R1] 8 bit read/write control
        `DCS_REG_CTRL_A: begin
          wv = merge({24'h000000, st.ctrl[0]}, avs_writedata, avs_byteenable);
          nx.ctrl[0] = wv[7:0];
        end
        `DCS_REG_CTRL_B: begin
          wv = merge({24'h000000, st.ctrl[1]}, avs_writedata, avs_byteenable);
          nx.ctrl[1] = wv[7:0];
        end
        `DCS_REG_BAND: begin
          wv = merge(rd_word, avs_writedata, avs_byteenable);
          nx.single_sel = wv[`DCS_BAND_SINGLE];
          nx.en = {wv[`DCS_BAND_EN_B], wv[`DCS_BAND_EN_A]};
          nx.irqen = {wv[`DCS_BAND_IRQEN_B], wv[`DCS_BAND_IRQEN_A]};
          // enabling channel b arms the level-taken first transfer
          if (wv[`DCS_BAND_EN_B] && !st.en[1]) begin
            nx.first_pend = 1'b1;
          end
        end
        `DCS_REG_MAR_A, `DCS_REG_MAR_B: begin
          wv = merge(rd_word, avs_writedata, avs_byteenable);
          nx.memory_addr_reg[widx == `DCS_REG_MAR_B] = wv[`DCS_ADDR_W-1:0];
          nx.mar_start[widx == `DCS_REG_MAR_B] = wv[`DCS_ADDR_W-1:0];
        end
        `DCS_REG_IO_ADDR_REG_A, `DCS_REG_IO_ADDR_REG_B: begin
          wv = merge(rd_word, avs_writedata, avs_byteenable);
          nx.io_addr_reg[widx == `DCS_REG_IO_ADDR_REG_B] = wv[15:0];
        end
        `DCS_REG_CNT_A, `DCS_REG_CNT_B: begin
          wv = merge(rd_word, avs_writedata, avs_byteenable);
          nx.cnt[widx == `DCS_REG_CNT_B] = wv[15:0];
        end
        `DCS_REG_STATUS: begin
          // write one to clear
          wv = merge(`DCS_ZERO32, avs_writedata, avs_byteenable);
          nx.sts = st.sts & ~wv[1:0];
        end
        `DCS_REG_MASK: begin
          wv = merge(rd_word, avs_writedata, avs_byteenable);
          nx.msk = wv[1:0];
        end
        default: ;
      endcase
    end
    // channel sequencing
    unique case (st.fsm)
      DCS_ST_IDLE: begin
        // [R13] channel a outranks channel b
        if (standby_n && hit[0] && st.en[0]) begin
          take[0] = 1'b1;
        end else if (standby_n && hit[1] && st.en[1]) begin
          take[1] = 1'b1;
        end
        if (take != 2'b00) begin
          nx.cur = take[1];
          nx.fsm = DCS_ST_BUSY;
          nx.xfer = build(take[1], st.ctrl[take[1]], st.memory_addr_reg[take[1]], st.io_addr_reg[take[1]], st.single_sel);
          // [R7] strobe only while a single address transfer runs
          nx.ack_n = !(take[1] && st.single_sel);
          if (take[1]) begin
            nx.first_pend = 1'b0;
          end
        end
      end
      DCS_ST_BUSY: begin
        if (xfer_done) begin
          nx.fsm = DCS_ST_IDLE;
          nx.xfer = '0;
          nx.ack_n = 1'b1;
          // [R4] idle mode leaves the address alone
          if (mode_cur != DCS_MODE_IDLE) begin
            nx.memory_addr_reg[st.cur] = step_addr(st.memory_addr_reg[st.cur], st.ctrl[st.cur][`DCS_BIT_SIZE],
                                       st.ctrl[st.cur][`DCS_BIT_STEP_DIR]);
          end
          if (mode_cur == DCS_MODE_RPT) begin
            // repeat: low count reloads and address rewinds
            if (st.cnt[st.cur][7:0] == `DCS_RPT_LAST) begin
              nx.cnt[st.cur][7:0] = st.cnt[st.cur][15:8];
              nx.memory_addr_reg[st.cur] = st.mar_start[st.cur];
            end else begin
              nx.cnt[st.cur][7:0] = st.cnt[st.cur][7:0] - `DCS_RPT_ONE;
            end
          end else begin
            nx.cnt[st.cur] = st.cnt[st.cur] - `DCS_CNT_ONE;
            if (st.cnt[st.cur] == `DCS_CNT_LAST) begin
              nx.en[st.cur] = 1'b0;
              // [R5] end interrupt only with irq enable; set beats clear
              if (st.irqen[st.cur]) begin
                nx.sts[st.cur] = 1'b1;
              end
            end
          end
        end
      end
    endcase
    // [R1] standby returns controls to reset values
    if (!standby_n) begin
      nx.ctrl = {`DCS_CTRL_RESET, `DCS_CTRL_RESET};
      nx.single_sel = 1'b0;
      nx.en = 2'b00;
      nx.irqen = 2'b00;
    end
    nx.irq = |(nx.sts & nx.msk);
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= DCS_ST_RST;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign xfer_out = st.xfer;
  assign xfer_ack_n = st.ack_n;
  assign irq = st.irq;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_done_a;
    st.fsm == DCS_ST_BUSY && xfer_done && !st.cur;
  endsequence

  a_bus_answer: assert property (@(posedge clock) disable iff (!resetn)
    s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");

  a_standby_clear: assert property (@(posedge clock) disable iff (!resetn) // [R1]
    !standby_n |=> st.ctrl == '0 && st.en == 2'b00) else $error("standby did not clear controls");

  a_size_out: assert property (@(posedge clock) disable iff (!resetn) // [R2]
    $rose(xfer_out.valid) |-> xfer_out.word == st.ctrl[st.cur][`DCS_BIT_SIZE]) else $error("size wrong");

  a_step_up: assert property (@(posedge clock) disable iff (!resetn) // [R3]
    s_done_a and (mode_cur == DCS_MODE_SEQ && !st.ctrl[0][`DCS_BIT_STEP_DIR])
    |=> st.memory_addr_reg[0] == $past(st.memory_addr_reg[0]) + ($past(st.ctrl[0][`DCS_BIT_SIZE]) ? `DCS_STEP_WORD : `DCS_STEP_BYTE))
    else $error("address step wrong");

  a_idle_hold: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    s_done_a and (mode_cur == DCS_MODE_IDLE) |=> $stable(st.memory_addr_reg[0])) else $error("idle moved address");

  a_end_flag: assert property (@(posedge clock) disable iff (!resetn) // [R5]
    s_done_a and (mode_cur != DCS_MODE_RPT && st.cnt[0] == `DCS_CNT_LAST && st.irqen[0])
    |=> st.sts[0] && !st.en[0]) else $error("end flag missing");

  a_dual_dir: assert property (@(posedge clock) disable iff (!resetn) // [R6]
    xfer_out.valid && !xfer_out.single |-> (st.ctrl[st.cur][`DCS_BIT_XDIR] ?
    xfer_out.dst == st.memory_addr_reg[st.cur] : xfer_out.src == st.memory_addr_reg[st.cur])) else $error("dual direction wrong");

  a_ack_strobe: assert property (@(posedge clock) disable iff (!resetn) // [R7]
    xfer_ack_n == !(xfer_out.valid && xfer_out.single)) else $error("ack strobe wrong");

  a_chan_a_ext: assert property (@(posedge clock) disable iff (!resetn) // [R11]
    st.ctrl[0][3:0] inside {`DCS_SRC_NONE, `DCS_SRC_EXT_EDGE, `DCS_SRC_EXT_LEVEL, 4'hE, 4'hF} |-> !hit[0])
    else $error("unassigned code fired on channel a");

  a_priority: assert property (@(posedge clock) disable iff (!resetn) // [R13]
    st.fsm == DCS_ST_IDLE && standby_n && hit == 2'b11 && st.en == 2'b11 |=> st.fsm == DCS_ST_BUSY && !st.cur)
    else $error("priority wrong");

  a_io_top: assert property (@(posedge clock) disable iff (!resetn) // [R15]
    xfer_out.valid && !xfer_out.single |-> (xfer_out.src[23:16] == `DCS_IO_TOP || xfer_out.dst[23:16] == `DCS_IO_TOP))
    else $error("io top byte wrong");
endmodule // dcs_top

// ---- verification/dcs_bus_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bus side partner: finishes each order after a set delay
// ----------------------------------------------------------------------
module dcs_bus_model import dcs_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // order from the block
  input wire dcs_xfer_t xfer,
  input wire logic xfer_ack_n,
  input wire logic [3:0] delay,
  // answers
  output logic done,
  output logic [15:0] ext_data
);
  logic [3:0] wait_r; // cycles spent on this order

  // done drops at once so one order never ends twice
  always_ff @(posedge clock) begin
    if (!resetn || !xfer.valid || done) begin
      wait_r <= 4'h0;
      done <= 1'b0;
    end else if (wait_r >= delay) begin
      done <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end

  // data only under strobe
  // outside the read strobe the lines toggle, never hold stale data
  always_ff @(posedge clock) begin
    if (!resetn) ext_data <= 16'h0000;
    else if (!xfer_ack_n && xfer.ack_read) ext_data <= 16'hA5C3;
    else ext_data <= ~ext_data;
  end
endmodule // dcs_bus_model

// ---- verification/test_dcs_top.sv ----
`timescale 1ns/1ps
module test_dcs_top import dcs_pkg::*;;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clock = 1'b0, resetn = 1'b0, standby_n = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, xfer_done, xfer_ack_n, irq, ack, d;
  dcs_req_t req_in = '0;
  logic ext_req_n = 1'b1; // pin idles high
  dcs_xfer_t xfer_out, x;
  logic [3:0] delay = 4'h0;
  logic [23:0] m;
  logic [15:0] io;
  int n_fail = 0, n_tests = 0, seed = 52, k;

  dcs_top i_dcs_top (.clock(clock), .resetn(resetn), .standby_n(standby_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_in(req_in), .ext_req_n(ext_req_n),
    .xfer_out(xfer_out), .xfer_done(xfer_done), .xfer_ack_n(xfer_ack_n), .irq(irq));
  dcs_bus_model i_dcs_bus_model (.clock(clock), .resetn(resetn), .xfer(xfer_out), .xfer_ack_n(xfer_ack_n),
    .delay(delay), .done(xfer_done), .ext_data());

  initial begin
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------------
  // one register access, held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait for an order, keep it, let it finish; drop requests if asked
  task automatic grab(input bit drop);
    int t;
    t = 0;
    delay <= 4'($random(seed));
    while (xfer_out.valid !== 1'b1 && t < 40) begin
      @(posedge clock);
      t++;
    end
    x = xfer_out;
    ack = xfer_ack_n;
    if (drop) begin
      req_in <= '0;
      ext_req_n <= 1'b1;
    end
    while (xfer_out.valid === 1'b1) @(posedge clock);
    @(posedge clock);
  endtask

  // whether a code starts the channel
  function automatic logic src_ok(input logic chb, input logic [3:0] c);
    return c == 4'h1 || (c >= 4'h4 && c <= 4'hD) || (chb && (c == 4'h2 || c == 4'h3));
  endfunction

  // only the request line a code should use; all lines for pin codes and dead codes
  function automatic dcs_req_t req_for(input logic [3:0] c);
    dcs_req_t r;
    r = '1;
    if (c == 4'h1) r = 11'h400;
    if (c >= 4'h4 && c <= 4'h7) r = 11'h001 << (13 - c);
    if (c >= 4'h8 && c <= 4'hD) r = 11'h001 << (c - 8);
    return r;
  endfunction

  // memory address after one transfer: idle holds, repeat at count one rewinds, else steps
  function automatic logic [23:0] exp_mar(input int c, input logic [23:0] a);
    logic [23:0] s;
    s = c[0] ? 24'h000002 : 24'h000001;
    if (c[2] && (c[3] || a[0])) return a;
    return c[1] ? a - s : a + s;
  endfunction

  // count after one transfer: repeat reloads its low byte at one, the others run to zero
  function automatic logic [15:0] exp_cnt(input int c, input logic [23:0] a);
    if (c[2] && !c[3]) return a[0] ? 16'h0202 : 16'h0201;
    return 16'h0000;
  endfunction

  task automatic end_sim;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    end_sim;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    bus(0, 6'h00, 0, q); chk(q, 0);
    bus(0, 6'h04, 0, q); chk(q, 0);
    bus(1, 6'h28, 3, q);
    // size, step direction, mode and direction on channel a
    for (k = 0; k < 16; k++) begin
      m = 24'($random(seed));
      io = 16'($random(seed));
      d = 1'($random(seed));
      bus(1, 6'h00, {k[0], k[1], k[2], d, 4'h1}, q);
      bus(0, 6'h00, 0, q); chk(q, {k[0], k[1], k[2], d, 4'h1});
      bus(1, 6'h0C, m, q);
      bus(1, 6'h14, io, q);
      // repeat runs either rewind (low count one) or step on (low count two)
      bus(1, 6'h1C, (k[2] && !k[3]) ? (m[0] ? 16'h0201 : 16'h0202) : 16'h0001, q);
      bus(1, 6'h08, k[3] ? 10 : 2, q);
      req_in <= 11'h400;
      grab(1);
      chk(x.word, k[0]);
      chk(x.src, d ? {8'hFF, io} : m);
      chk(x.dst, d ? m : {8'hFF, io});
      bus(0, 6'h0C, 0, q); chk(q, exp_mar(k, m));
      bus(0, 6'h1C, 0, q); chk(q, exp_cnt(k, m));
      bus(0, 6'h24, 0, q); chk(q, k[3]);
      chk(irq, k[3]);
      bus(1, 6'h24, 1, q);
      bus(1, 6'h08, 0, q);
      chk(irq, 0);
    end
    // every activation code on both channels
    for (k = 0; k < 32; k++) begin
      bus(1, k[4] ? 6'h04 : 6'h00, k[3:0], q);
      bus(1, k[4] ? 6'h20 : 6'h1C, 1, q);
      bus(1, 6'h08, k[4] ? 4 : 2, q);
      req_in <= req_for(k[3:0]);
      ext_req_n <= 1'b0;
      grab(1);
      chk(x.valid, src_ok(k[4], k[3:0]));
      bus(1, 6'h08, 0, q);
    end
    // same source on both channels: a first, then b in dual mode
    bus(1, 6'h00, 1, q); bus(1, 6'h04, 1, q); bus(1, 6'h1C, 1, q); bus(1, 6'h20, 1, q);
    bus(1, 6'h08, 6, q);
    req_in <= 11'h400;
    grab(0); chk(x.chan_b, 0);
    grab(1); chk(x.chan_b, 1);
    chk(ack, 1);
    // single address mode on channel b, both directions
    for (k = 0; k < 2; k++) begin
      m = 24'($random(seed));
      bus(1, 6'h04, {k[0], 4'h3}, q); bus(1, 6'h10, m, q); bus(1, 6'h20, 1, q); bus(1, 6'h08, 5, q);
      ext_req_n <= 1'b0;
      grab(1);
      chk(ack, 0);
      chk(x.ack_read, k[0]);
      chk(k[0] ? x.dst : x.src, m);
    end
    // standby clears control; unmapped word reads zero
    bus(1, 6'h00, 8'hA5, q);
    standby_n <= 1'b0;
    @(posedge clock);
    standby_n <= 1'b1;
    bus(0, 6'h00, 0, q); chk(q, 0);
    bus(0, 6'h30, 0, q); chk(q, 0);
    end_sim;
  end
endmodule // test_dcs_top
